/* dv/testbench.sv */
// Self-checking bench for uaux_core with a remote serial peer sending on pad 1 and listening on pad 0.
// Assumes 40 MHz sys_clk; unused pads idle high as if pulled up.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic                sys_clk, srst, cfgWrite, syncBusy, txWrite, rxRead, rxValid, sleepReq;
    logic                irq, wakeRequest, oscRequest, portClockOn, loopbackActive, remoteTx;
    uaux_pkg::uaux_cfg_t cfgIn, c;
    uaux_pkg::uaux_err_t errorClear, errorFlags;
    logic [3:0]          irqEnableSet, irqEnableClear, irqFlagsClear, irqEnable, irqFlags;
    logic [3:0]          padIn, padOut, padOe;
    logic [7:0]          txData, rxData;
    logic [8:0]          got;
    int                  n_errors = 0, n_tests = 0, cycles = 0;
    assign padIn = (padOe & padOut) | (~padOe & {2'h3, remoteTx, 1'h1});
    uaux_core uut (.*, .serialClockLine(1'h0));
    uaux_remote remote (.sys_clk(sys_clk), .rxLine(padIn[0]), .txLine(remoteTx));
    initial begin
        sys_clk = 1'h0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            close_out();
        end
    end
    task automatic close_out();
        if (n_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : close_out
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(negedge sys_clk);
    endtask : tick
    task automatic apply(input uaux_pkg::uaux_cfg_t v);
        cfgIn = v;
        cfgWrite = 1'h1;
        tick(1);
        cfgWrite = 1'h0;
        tick(3);
    endtask : apply
    task automatic wait_rx();
        for (int i = 0; i < 400 && rxValid !== 1'h1; i++) tick(1);
        check(rxValid, 1'h1);
    endtask : wait_rx
    // Pops the head and drops the start flag together
    task automatic pop();
        rxRead = 1'h1;
        irqFlagsClear = 4'h8;
        tick(1);
        rxRead = 1'h0;
        irqFlagsClear = 4'h0;
        tick(1);
        check(irqFlags[3], 1'h0);
    endtask : pop
    task automatic send_tx(input logic [7:0] d);
        txData = d;
        txWrite = 1'h1;
        tick(1);
        txWrite = 1'h0;
    endtask : send_tx
    initial begin
        {srst, cfgWrite, txWrite, rxRead, sleepReq} = 5'h10;
        {irqEnableSet, irqEnableClear, irqFlagsClear, errorClear} = 14'h0;
        cfgIn = uaux_pkg::CFG_RESET;
        txData = 8'h00;
        tick(16);
        srst = 1'h0;
        tick(1);
        check(irqFlags, uaux_pkg::FLAGS_RESET);
        irqEnableSet = 4'hc;
        tick(1);
        irqEnableSet = 4'h0;
        irqEnableClear = 4'h4;
        tick(1);
        irqEnableClear = 4'h0;
        tick(1);
        check(irqEnable, 4'h8);
        c = uaux_pkg::CFG_RESET;
        c.frameFormat = uaux_pkg::FRAME_FORMAT_PARITY;
        c.rxPadSelect = 2'h1;
        {c.startDetectEnable, c.rxEnable, c.txEnable} = 3'h7;
        c.baudDiv = 16'h0000;
        for (int p = 0; p < 2; p++) begin
            c.paritySelect = p[0];
            apply(c);
            remote.send(8'h5b, ^8'h5b ^ p[0]);
            check({irqFlags[3], irq}, 2'h3);
            wait_rx();
            check({rxData, errorFlags.parityError}, {8'h5b, 1'h0});
            pop();
            remote.send(8'h5b, ~(^8'h5b ^ p[0]));
            wait_rx();
            tick(5);
            check(errorFlags.parityError, 1'h1);
            errorClear = 2'h1;
            tick(1);
            errorClear = 2'h0;
            tick(1);
            check(errorFlags.parityError, 1'h0);
            pop();
            send_tx(8'ha6);
            remote.recv(got);
            check(got, {^8'ha6 ^ p[0], 8'ha6});
            tick(40);
            check(irqFlags[1], 1'h1);
        end
        c.rxPadSelect = 2'h0;
        apply(c);
        check({loopbackActive, padOe[0]}, 2'h3);
        irqEnableSet = 4'h4;
        irqEnableClear = 4'h8;
        send_tx(8'hc3);
        {irqEnableSet, irqEnableClear} = 8'h0;
        tick(2);
        sleepReq = 1'h1;
        tick(20);
        check({oscRequest, wakeRequest}, 2'h2);
        wait_rx();
        tick(2);
        check({rxData, wakeRequest}, {8'hc3, 1'h1});
        pop();
        tick(3);
        check(portClockOn, 1'h0);
        sleepReq = 1'h0;
        c.keepRunningInStandby = 1'h1;
        apply(c);
        sleepReq = 1'h1;
        tick(3);
        check(portClockOn, 1'h1);
        close_out();
    end
endmodule : testbench
`default_nettype wire

/* dv/uaux_core_sva.sv */
// Port-level checker for the serial port auxiliary block.
// Assumes the single sys_clk domain and synchronous srst.
`timescale 1ns/1ps
`default_nettype none
module uaux_core_sva (
    input wire logic                sys_clk,
    input wire logic                srst,
    input wire logic                cfgWrite,
    input wire logic                syncBusy,
    input wire logic [3:0]          irqEnableSet,
    input wire logic [3:0]          irqEnableClear,
    input wire uaux_pkg::uaux_err_t errorClear,
    input wire logic                rxValid,
    input wire logic [3:0]          padOe,
    input wire logic [3:0]          irqEnable,
    input wire logic [3:0]          irqFlags,
    input wire uaux_pkg::uaux_err_t errorFlags,
    input wire logic                irq
);
    logic [3:0] clrOnly;
    logic       perrClr;
    assign clrOnly = irqEnableClear & ~irqEnableSet;
    assign perrClr = errorClear.parityError;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    sequence cfg_taken;
        cfgWrite ##1 !cfgWrite ##1 !cfgWrite;
    endsequence
    irq_request_a:
        assert property (irq == |(irqFlags & irqEnable)) else $error("irq mismatch");
    enable_set_a:
        assert property (irqEnableSet != 4'h0 |=> (irqEnable & $past(irqEnableSet))
            == $past(irqEnableSet)) else $error("enable set lost");
    enable_clear_a:
        assert property (clrOnly != 4'h0 |=> (irqEnable & $past(clrOnly)) == 4'h0)
            else $error("enable clear lost");
    enable_hold_a:
        assert property (irqEnableSet == 4'h0 && irqEnableClear == 4'h0 |=> $stable(irqEnable))
            else $error("enable changed without strobe");
    sync_busy_a:
        assert property (cfgWrite |=> syncBusy) else $error("busy not raised");
    sync_done_a:
        assert property (cfg_taken |=> !syncBusy) else $error("busy not dropped");
    parity_error_flag_sticky_a:
        assert property ($fell(errorFlags.parityError) |-> $past(perrClr) || $past(syncBusy)
            || $past(syncBusy, 2)) else $error("parity error dropped");
    rxc_buffer_a:
        assert property (irqFlags[uaux_pkg::IRQ_RXC] == rxValid) else $error("rxc vs buffer");
    tx_pad_a:
        assert property ((padOe & 4'ha) == 4'h0) else $error("non-tx pad driven");
endmodule : uaux_core_sva
bind uaux_core uaux_core_sva chk (.*);
`default_nettype wire

/* dv/uaux_remote.sv */
// Remote asynchronous serial peer: sends frames, captures transmitted ones.
// Assumes 16 sys_clk cycles per bit (divider zero, 16-fold ticks).
`timescale 1ns/1ps
`default_nettype none
module uaux_remote #(
    parameter int unsigned BIT = 16
) (
    input  wire logic sys_clk,
    input  wire logic rxLine,
    output var logic  txLine
);
    initial txLine = 1'h1;
    // Exact bit time, so baud error is zero
    task automatic send(input logic [7:0] d, input logic par);
        logic [10:0] f;
        f = {1'h1, par, d, 1'h0};
        for (int i = 0; i < 11; i++) begin
            @(negedge sys_clk);
            txLine = f[i];
            repeat (BIT - 1) @(negedge sys_clk);
        end
    endtask : send
    task automatic recv(output logic [8:0] got);
        @(negedge rxLine);
        repeat (BIT / 2) @(posedge sys_clk);
        for (int i = 0; i < 9; i++) begin
            repeat (BIT) @(posedge sys_clk);
            got[i] = rxLine;
        end
    endtask : recv
endmodule : uaux_remote
`default_nettype wire

/* rtl/uaux_core.sv */
// Serial port with parity, pad loop-back, start-of-frame wake, four
// interrupt sources and sleep handling. Assumes sys_clk at 40 MHz,
// pads and serial clock arriving asynchronously, control as plain ports.
//
// How it works
// - Frame format one turns parity on.
// - Even parity: bit is one on odd ones.
// - Odd parity: total ones come out odd.
// - Receiver checks parity, sets parity error flag.
// - Same rx and tx pad loops back.
// - Falling rx edge wakes oscillator and clock.
// - Start detect only when its enable set.
// - Receive start flag raised at start bit.
// - Without it, clock held through frame.
// - Four flags set on their conditions.
// - Enable set and clear pulses, ones only.
// - Request held while flag set and enabled.
// - One request line for all sources.
// - Sources reach wake while asleep.
// - Internal clock, keep running: any wake.
// - External clock, keep running: receive-complete wakes.
// - Internal, not running: stop after transfer.
// - External, not running: drop new reception.
// - Configuration writes pass a synchroniser.
// - Asynchronous receive uses sixteen-fold oversampling.
// - Error flags stick until one or disable.
// - Receive complete set on buffer push.
`timescale 1ns/1ps
`default_nettype none
module uaux_core #(
    parameter int unsigned DATA_W = uaux_pkg::DATA_W_DEF
) (
    input  wire logic                            sys_clk,
    input  wire logic                            srst,
    input  wire logic                            cfgWrite,
    input  wire uaux_pkg::uaux_cfg_t             cfgIn,
    output logic                                 syncBusy,
    input  wire logic [3:0]                      irqEnableSet,
    input  wire logic [3:0]                      irqEnableClear,
    input  wire logic [3:0]                      irqFlagsClear,
    input  wire uaux_pkg::uaux_err_t             errorClear,
    input  wire logic                            txWrite,
    input  wire logic [DATA_W-1:0]               txData,
    input  wire logic                            rxRead,
    output logic [DATA_W-1:0]                    rxData,
    output logic                                 rxValid,
    input  wire logic [uaux_pkg::PAD_N-1:0]      padIn,
    output logic [uaux_pkg::PAD_N-1:0]           padOut,
    output logic [uaux_pkg::PAD_N-1:0]           padOe,
    input  wire logic                            serialClockLine,
    input  wire logic                            sleepReq,
    output logic [3:0]                           irqEnable,
    output logic [3:0]                           irqFlags,
    output uaux_pkg::uaux_err_t                  errorFlags,
    output logic                                 irq,
    output logic                                 wakeRequest,
    output logic                                 oscRequest,
    output logic                                 portClockOn,
    output logic                                 loopbackActive
);
    initial begin
        if (DATA_W < 5 || DATA_W > 9) $error("uaux_core: DATA_W out of range");
    end

    localparam logic [3:0] PH_LAST = 4'(uaux_pkg::OVS_LAST);
    localparam logic [3:0] PH_LO   = 4'(uaux_pkg::OVS_VOTE_LO);
    localparam logic [3:0] PH_HI   = 4'(uaux_pkg::OVS_VOTE_HI);
    localparam logic [3:0] BITS_M1 = 4'(DATA_W - 1);
    localparam logic [1:0] SYNC_M1 = 2'(uaux_pkg::SYNC_STAGES - 1);

    uaux_pkg::uaux_cfg_t cfg;
    uaux_pkg::uaux_cfg_t cfgStage;
    logic [1:0]          syncCnt;

    // Configuration crossing into the port core
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cfg      <= uaux_pkg::CFG_RESET;
            cfgStage <= uaux_pkg::CFG_RESET;
            syncCnt  <= 2'h0;
            syncBusy <= 1'b0;
        end else if (cfgWrite) begin
            cfgStage <= cfgIn;
            syncCnt  <= SYNC_M1;
            syncBusy <= 1'b1;
        end else if (syncBusy) begin
            if (syncCnt == 2'h0) begin
                cfg      <= cfgStage;
                syncBusy <= 1'b0;
            end else begin
                syncCnt <= syncCnt - 2'h1;
            end
        end
    end

    wire logic parityOn = (cfg.frameFormat == uaux_pkg::FRAME_FORMAT_PARITY);

    // Pads and serial clock cross in through two flops each
    logic [uaux_pkg::PAD_N-1:0] padMeta;
    logic [uaux_pkg::PAD_N-1:0] padSync;
    logic [1:0]                 sckSync;
    logic                       sckPrev;
    logic                       rxPrev;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            padMeta <= '1;
            padSync <= '1;
            sckSync <= 2'h0;
            sckPrev <= 1'b0;
            rxPrev  <= 1'b1;
        end else begin
            padMeta <= padIn;
            padSync <= padMeta;
            sckSync <= {sckSync[0], serialClockLine};
            sckPrev <= sckSync[1];
            rxPrev  <= padSync[cfg.rxPadSelect];
        end
    end

    // Receive reads the chosen pad; when it is the tx pad we hear ourselves
    wire logic rxLine    = padSync[cfg.rxPadSelect];
    wire logic [1:0] txPad = cfg.txPadSelect ? 2'h2 : 2'h0;

    // Bit-rate tick: divider or rising serial clock edge
    logic [15:0] baudCnt;
    logic        baseTick;
    always_ff @(posedge sys_clk) begin
        if (srst || cfg.clockExternal) begin
            baudCnt  <= 16'h0000;
            baseTick <= cfg.clockExternal && !srst && sckSync[1] && !sckPrev;
        end else if (baudCnt >= cfg.baudDiv) begin
            baudCnt  <= 16'h0000;
            baseTick <= 1'b1;
        end else begin
            baudCnt  <= baudCnt + 16'h0001;
            baseTick <= 1'b0;
        end
    end
    wire logic tick = baseTick && portClockOn;

    // Sync mode takes one tick per bit, async sixteen
    wire logic [3:0] phLast = cfg.syncMode ? 4'h0 : PH_LAST;

    uaux_pkg::uaux_ser_t txState;
    logic [DATA_W-1:0]   txHold;
    logic                txHoldFull;
    logic [DATA_W-1:0]   txShift;
    logic [3:0]          txPhase;
    logic [3:0]          txBit;
    logic                txParity;
    logic                txDone;
    logic                txPin;
    logic                txParityCalc;

    uaux_parity #(.W(DATA_W)) u_txPar (
        .data      (txHold),
        .oddSel    (cfg.paritySelect),
        .parityBit (txParityCalc)
    );

    wire logic txBitEnd = tick && (txPhase == phLast);
    wire logic txBusy   = (txState != uaux_pkg::SER_IDLE);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            txState    <= uaux_pkg::SER_IDLE;
            txHold     <= '0;
            txHoldFull <= 1'b0;
            txShift    <= '0;
            txPhase    <= 4'h0;
            txBit      <= 4'h0;
            txParity   <= 1'b0;
            txDone     <= 1'b0;
            txPin      <= 1'b1;
        end else begin
            txDone <= 1'b0;
            if (txWrite && !txHoldFull) begin
                txHold     <= txData;
                txHoldFull <= 1'b1;
            end
            if (txBusy && tick) begin
                txPhase <= txBitEnd ? 4'h0 : txPhase + 4'h1;
            end
            case (txState)
                uaux_pkg::SER_IDLE: begin
                    txPin <= 1'b1;
                    if (txHoldFull && cfg.txEnable && portClockOn) begin
                        txShift    <= txHold;
                        txParity   <= txParityCalc;
                        txHoldFull <= 1'b0;
                        txPhase    <= 4'h0;
                        txPin      <= 1'b0;
                        txState    <= uaux_pkg::SER_START;
                    end
                end
                uaux_pkg::SER_START: begin
                    if (txBitEnd) begin
                        txPin   <= txShift[0];
                        txBit   <= 4'h0;
                        txState <= uaux_pkg::SER_DATA;
                    end
                end
                uaux_pkg::SER_DATA: begin
                    if (txBitEnd) begin
                        if (txBit == BITS_M1) begin
                            txPin   <= parityOn ? txParity : 1'b1;
                            txState <= parityOn ? uaux_pkg::SER_PARITY
                                                : uaux_pkg::SER_STOP;
                        end else begin
                            txPin   <= txShift[1];
                            txShift <= txShift >> 1;
                            txBit   <= txBit + 4'h1;
                        end
                    end
                end
                uaux_pkg::SER_PARITY: begin
                    if (txBitEnd) begin
                        txPin   <= 1'b1;
                        txState <= uaux_pkg::SER_STOP;
                    end
                end
                uaux_pkg::SER_STOP: begin
                    if (txBitEnd) begin
                        txState <= uaux_pkg::SER_IDLE;
                        txDone  <= !txHoldFull;
                    end
                end
                default: txState <= uaux_pkg::SER_IDLE;
            endcase
        end
    end

    // Tx pad driven only while the transmitter is enabled
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            padOut <= '1;
            padOe  <= '0;
        end else begin
            padOut <= '1;
            padOe  <= '0;
            padOut[txPad] <= txPin;
            padOe[txPad]  <= cfg.txEnable;
        end
    end

    uaux_pkg::uaux_ser_t rxState;
    logic [DATA_W-1:0]   rxShift;
    logic [3:0]          rxPhase;
    logic [3:0]          rxBit;
    logic [1:0]          rxVotes;
    logic                rxParityBit;
    logic                rxPush;
    logic                rxPushPerr;
    logic                rxPushFerr;
    logic                rxParityCalc;
    logic                sofHold;

    uaux_parity #(.W(DATA_W)) u_rxPar (
        .data      (rxShift),
        .oddSel    (cfg.paritySelect),
        .parityBit (rxParityCalc)
    );

    // Asleep on an external clock without keep-running: no reception starts
    wire logic rxDrop = sleepReq && cfg.clockExternal
                        && !cfg.keepRunningInStandby;
    wire logic rxIdle = (rxState == uaux_pkg::SER_IDLE);
    wire logic startEdge = rxIdle && cfg.rxEnable && !rxDrop
                           && rxPrev && !rxLine;
    wire logic rxBitEnd = tick && (rxPhase == phLast);
    // Majority of three mid samples; sync mode takes the line as is
    wire logic rxVoteBit = cfg.syncMode ? rxLine
                         : ((rxVotes + 2'(rxLine && rxPhase == PH_HI)) >= 2'h2);

    always_ff @(posedge sys_clk) begin
        if (srst || !cfg.rxEnable) begin
            rxState     <= uaux_pkg::SER_IDLE;
            rxShift     <= '0;
            rxPhase     <= 4'h0;
            rxBit       <= 4'h0;
            rxVotes     <= 2'h0;
            rxParityBit <= 1'b0;
            rxPush      <= 1'b0;
            rxPushPerr  <= 1'b0;
            rxPushFerr  <= 1'b0;
        end else begin
            rxPush <= 1'b0;
            if (!rxIdle && tick) begin
                rxPhase <= rxBitEnd ? 4'h0 : rxPhase + 4'h1;
                if (rxBitEnd) begin
                    rxVotes <= 2'h0;
                end else if (rxPhase >= PH_LO && rxPhase <= PH_HI && rxLine) begin
                    rxVotes <= rxVotes + 2'h1;
                end
            end
            case (rxState)
                uaux_pkg::SER_IDLE: begin
                    if (startEdge) begin
                        rxPhase <= 4'h0;
                        rxVotes <= 2'h0;
                        rxState <= uaux_pkg::SER_START;
                    end
                end
                uaux_pkg::SER_START: begin
                    if (rxBitEnd) begin
                        rxBit   <= 4'h0;
                        rxState <= rxVoteBit ? uaux_pkg::SER_IDLE
                                             : uaux_pkg::SER_DATA;
                    end
                end
                uaux_pkg::SER_DATA: begin
                    if (rxBitEnd) begin
                        rxShift <= {rxVoteBit, rxShift[DATA_W-1:1]};
                        rxBit   <= rxBit + 4'h1;
                        if (rxBit == BITS_M1) begin
                            rxState <= parityOn ? uaux_pkg::SER_PARITY
                                                : uaux_pkg::SER_STOP;
                        end
                    end
                end
                uaux_pkg::SER_PARITY: begin
                    if (rxBitEnd) begin
                        rxParityBit <= rxVoteBit;
                        rxState     <= uaux_pkg::SER_STOP;
                    end
                end
                uaux_pkg::SER_STOP: begin
                    if (rxBitEnd) begin
                        rxPush     <= 1'b1;
                        rxPushFerr <= !rxVoteBit;
                        rxPushPerr <= parityOn && (rxParityCalc != rxParityBit);
                        rxState    <= uaux_pkg::SER_IDLE;
                    end
                end
                default: rxState <= uaux_pkg::SER_IDLE;
            endcase
        end
    end

    // Two-entry receive buffer; entry 0 is the head shown on rxData
    logic [DATA_W-1:0] rxSecond;
    logic [1:0]        rxCount;
    wire logic pop  = rxRead && (rxCount != 2'h0);
    wire logic push = rxPush && (rxCount != 2'h2 || pop);
    // Fill after this edge; rxValid and the receive-complete flag both follow it
    wire logic [1:0] rxLevel = cfg.rxEnable ? rxCount + 2'(push) - 2'(pop) : 2'h0;
    always_ff @(posedge sys_clk) begin
        if (srst || !cfg.rxEnable) begin
            rxData   <= '0;
            rxSecond <= '0;
            rxCount  <= 2'h0;
            rxValid  <= 1'b0;
        end else begin
            if (pop) begin
                rxData <= (push && rxCount == 2'h1) ? rxShift : rxSecond;
            end else if (push && rxCount == 2'h0) begin
                rxData <= rxShift;
            end
            if (push && (rxCount == 2'h2 || (rxCount == 2'h1 && !pop))) begin
                rxSecond <= rxShift;
            end
            rxCount <= rxLevel;
            rxValid <= rxLevel != 2'h0;
        end
    end

    // Sticky errors: set beats clear, disable wipes them
    always_ff @(posedge sys_clk) begin
        if (srst || !cfg.rxEnable) begin
            errorFlags <= '0;
        end else begin
            errorFlags.parityError <= (rxPush && rxPushPerr)
                || (errorFlags.parityError && !errorClear.parityError);
            errorFlags.frameError  <= (rxPush && rxPushFerr)
                || (errorFlags.frameError && !errorClear.frameError);
        end
    end

    // Start-of-frame hold keeps the clock alive until the frame ends
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            sofHold <= 1'b0;
        end else if (startEdge && cfg.startDetectEnable) begin
            sofHold <= 1'b1;
        end else if (rxIdle) begin
            sofHold <= 1'b0;
        end
    end

    wire logic transferBusy = txBusy || !rxIdle || txHoldFull;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            portClockOn <= 1'b1;
            oscRequest  <= 1'b0;
        end else begin
            // Clock stops only once the running transfer is over
            portClockOn <= !sleepReq || cfg.keepRunningInStandby
                           || transferBusy || sofHold;
            oscRequest  <= sofHold && sleepReq;
        end
    end

    // Flags: hardware set wins over a same-cycle clear
    logic [3:0] next_flags;
    // Registered irq then matches flags and enables of one and the same cycle
    wire logic [3:0] next_enable = (irqEnable & ~irqEnableClear) | irqEnableSet;
    always_comb begin
        next_flags = irqFlags;
        next_flags[uaux_pkg::IRQ_DRE] = !txHoldFull;
        next_flags[uaux_pkg::IRQ_RXC] = (rxLevel != 2'h0);
        next_flags[uaux_pkg::IRQ_TXC] = txDone
            || (irqFlags[uaux_pkg::IRQ_TXC] && !irqFlagsClear[uaux_pkg::IRQ_TXC]
                && !txWrite);
        next_flags[uaux_pkg::IRQ_RXS] = (startEdge && cfg.startDetectEnable)
            || (irqFlags[uaux_pkg::IRQ_RXS]
                && !irqFlagsClear[uaux_pkg::IRQ_RXS]);
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irqFlags  <= uaux_pkg::FLAGS_RESET;
            irqEnable <= uaux_pkg::ENABLE_RESET;
        end else begin
            irqFlags  <= next_flags;
            irqEnable <= next_enable;
        end
    end

    // Wake mask depends on clock source and keep-running
    wire logic internalRun = cfg.keepRunningInStandby && !cfg.clockExternal;
    wire logic [3:0] wakeMask = internalRun ? 4'hf
        : {cfg.startDetectEnable && !cfg.clockExternal, 3'b100};
    wire logic [3:0] pending = next_flags & next_enable;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq            <= 1'b0;
            wakeRequest    <= 1'b0;
            loopbackActive <= 1'b0;
        end else begin
            irq            <= |pending;
            wakeRequest    <= sleepReq && |(pending & wakeMask);
            loopbackActive <= (cfg.rxPadSelect == txPad) && cfg.txEnable;
        end
    end

endmodule : uaux_core
`default_nettype wire

/* rtl/uaux_parity.sv */
// Parity bit over a data word, even or odd.
// Pure combinational; used for both transmit generation and receive check.
`timescale 1ns/1ps
`default_nettype none
module uaux_parity #(
    parameter int unsigned W = 8
) (
    input  wire logic [W-1:0] data,
    input  wire logic         oddSel,
    output logic              parityBit
);
    initial begin
        if (W < 5 || W > 9) $error("uaux_parity: width out of range");
    end

    // Even: one when data has odd ones; odd: the inverse
    assign parityBit = (^data) ^ oddSel;
endmodule : uaux_parity
`default_nettype wire

/* rtl/uaux_pkg.sv */
// Shared constants and carrier types for the serial port auxiliary block.
// Assumes one system clock; all users refer to names as uaux_pkg::name.
package uaux_pkg;

    localparam int unsigned SYS_CLK_HZ   = 40_000_000;
    localparam int unsigned SYNC_STAGES  = 2;
    localparam int unsigned OVS          = 16;
    localparam int unsigned OVS_LAST     = OVS - 1;
    localparam int unsigned OVS_VOTE_LO  = 7;
    localparam int unsigned OVS_VOTE_HI  = 9;
    localparam int unsigned PAD_N        = 4;
    localparam int unsigned DATA_W_DEF   = 8;

    localparam logic [3:0]  FRAME_FORMAT_PLAIN   = 4'h0;
    localparam logic [3:0]  FRAME_FORMAT_PARITY  = 4'h1;
    localparam logic [15:0] BAUD_RESET   = 16'h0000;
    localparam logic [3:0]  ENABLE_RESET = 4'h0;
    localparam logic [3:0]  FLAGS_RESET  = 4'h1;

    localparam int unsigned IRQ_DRE = 0;
    localparam int unsigned IRQ_TXC = 1;
    localparam int unsigned IRQ_RXC = 2;
    localparam int unsigned IRQ_RXS = 3;

    typedef struct packed {
        logic [3:0]  frameFormat;
        logic        paritySelect;
        logic [1:0]  rxPadSelect;
        logic        txPadSelect;
        logic        startDetectEnable;
        logic        keepRunningInStandby;
        logic        clockExternal;
        logic        syncMode;
        logic        rxEnable;
        logic        txEnable;
        logic [15:0] baudDiv;
    } uaux_cfg_t;

    localparam uaux_cfg_t CFG_RESET = '{
        frameFormat: FRAME_FORMAT_PLAIN, paritySelect: 1'b0, rxPadSelect: 2'h0,
        txPadSelect: 1'b0, startDetectEnable: 1'b0,
        keepRunningInStandby: 1'b0, clockExternal: 1'b0, syncMode: 1'b0,
        rxEnable: 1'b0, txEnable: 1'b0, baudDiv: BAUD_RESET};

    typedef struct packed {
        logic frameError;
        logic parityError;
    } uaux_err_t;

    typedef enum logic [2:0] {
        SER_IDLE,
        SER_START,
        SER_DATA,
        SER_PARITY,
        SER_STOP
    } uaux_ser_t;

endpackage : uaux_pkg
